// ===== verilog/seq_switch_ctrl.sv
// sequence switch control: selection timing, blank pre-step, once repeat, sync lock
//
// Behaviour
// RQ1: in coherent timing a new selection waits until the playing sequence reaches its end.
// RQ2: in immediate timing, the default, a new selection aborts the current sequence at once.
// RQ3: the same transition timing applies to bus and external port selections.
// RQ4: the blank pre-step acts only in armed continuous operation with the bus arming event; here it also acts with CTRL_ONCE set.
// RQ5: with the blank pre-step a DC item plays first and the first trigger moves to step 1.
// RQ6: at the end of such a sequence it restarts from step 1 without the blank pre-step.
// RQ7: the blank pre-step is not a table step and does not count in numbering or length.
// RQ8: with the waveform pre-step the first table waveform is issued as soon as selected.
// RQ9: in once mode the sequence runs the once count of passes and then goes idle.
// RQ10: once counts of 1 to 16,777,216 are accepted and the count is 1 after reset.
// RQ11: the sync pulse sits on step 1 by default and moves to any step from 1 to 49,152.
// RQ12: the sync pulse lasts exactly as long as the waveform of the sync-locked step.
// RQ13: a sequence reset command forces the active sequence back to its first step.
// RQ14: the external selector drives an 8-bit sequence number and one valid line.
// RQ15: up to 1,000 sequence tables per channel are held and any can be made active.
// RQ16: a selection arriving while a coherent switch is pending replaces its target.
//
// Chosen here: register access over APB and the register offsets.
module seq_switch_ctrl
  import seq_switch_pkg::*;
#(
  parameter int MAX_SEQ  = 1000,
  parameter int MAX_STEP = 49152,
  parameter int MAX_ONCE = 16777216
)
(
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // external sequence select port
  input  wire logic [EXT_W-1:0]  EXT_SEL,
  input  wire logic              EXT_VALID,
  // step item stream toward the waveform player
  output logic                   ITEM_VALID,
  input  wire logic              ITEM_READY,
  output logic                   ITEM_DC,
  output logic      [SEQ_W-1:0]  ITEM_SEQ,
  output logic      [STEP_W-1:0] ITEM_STEP,
  // end of the waveform that is playing, and sync output
  input  wire logic              STEP_DONE,
  output logic                   SYNC_OUT
);

  // the external port must reach every sequence code that it can carry
  if (MAX_SEQ < (1 << EXT_W) || MAX_SEQ > 1000 || MAX_STEP < 3 || MAX_STEP > 65535
      || MAX_ONCE < 1 || MAX_ONCE > 33554431)
  begin : g_param_check
    $error("seq_switch_ctrl: parameter out of range");
  end

  typedef struct packed {
    logic              dc;
    logic [SEQ_W-1:0]  seq;
    logic [STEP_W-1:0] step;
  } item_t;

  typedef struct packed {
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [ONCE_W-1:0]     once_cnt;
    logic [STEP_W-1:0]     lock;
    seq_state_t            state;
    logic [SEQ_W-1:0]      active;
    logic [STEP_W-1:0]     step;
    logic [ONCE_W-1:0]     passes;
    logic                  blank_sent;
    logic                  pend_v;
    logic [SEQ_W-1:0]      pend_seq;
    logic                  out_v;
    item_t                 out_d;
    logic                  skid_v;
    item_t                 skid_d;
    logic                  sync;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [STEP_W-1:0] len_mem [0:MAX_SEQ-1];
  logic              len_we;
  logic [SEQ_W-1:0]  len_wseq;
  logic [STEP_W-1:0] len_wdata;

  function automatic logic seq_ok(input logic [31:0] v);
    seq_ok = (v >= 32'h1) && (v <= 32'(MAX_SEQ));
  endfunction : seq_ok

  function automatic logic [SEQ_W-1:0] seq_index(input logic [SEQ_W-1:0] s);
    seq_index = s - SEQ_RESET;
  endfunction : seq_index

  ////////////////////////////////////////////////////////////////////////////
  // sequence length tables, one entry per stored sequence

  always_ff @(posedge REF_CLK)
  begin
    if (len_we) // [RQ15]
      len_mem[seq_index(len_wseq)] <= len_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic              acc;
    logic              wr;
    logic              sel_req;
    logic [SEQ_W-1:0]  sel_seq;
    logic              cmd_reset;
    logic              cmd_trig;
    logic [STEP_W-1:0] cur_len;
    logic              blank_ok;
    logic              do_start;
    logic [SEQ_W-1:0]  start_seq;
    logic              flush;
    logic              push;
    item_t             push_d;
    logic              in_ready;
    logic              pop;

    state_next = state_reg;
    acc        = PSEL && PENABLE && state_reg.pready;
    wr         = acc && PWRITE;
    sel_req    = 1'b0;
    sel_seq    = state_reg.active;
    cmd_reset  = 1'b0;
    cmd_trig   = 1'b0;
    cur_len    = len_mem[seq_index(state_reg.active)];
    do_start   = 1'b0;
    start_seq  = state_reg.active;
    flush      = 1'b0;
    push       = 1'b0;
    push_d     = '0;
    in_ready   = 1'b0;
    pop        = 1'b0;
    len_we     = 1'b0;
    len_wseq   = PWDATA[TABLE_SEQ_LSB +: SEQ_W];
    len_wdata  = PWDATA[TABLE_LEN_LSB +: STEP_W];
    blank_ok   = state_reg.ctrl[CTRL_BLANK_DC] && state_reg.ctrl[CTRL_ARMED]
                 && state_reg.ctrl[CTRL_ARM_BUS]; // [RQ4]

    // apb: zero wait states, answer on the cycle after setup
    state_next.pready  = PSEL && !PENABLE;
    state_next.pslverr = 1'b0;
    state_next.prdata  = '0;
    if (PSEL && !PENABLE)
    begin
      state_next.pslverr = 1'b0;
      case (PADDR)
        CTRL_ADDR:   state_next.prdata = 32'(state_reg.ctrl);
        SELECT_ADDR: state_next.prdata = 32'(state_reg.active);
        ONCE_ADDR:   state_next.prdata = 32'(state_reg.once_cnt);
        LOCK_ADDR:   state_next.prdata = 32'(state_reg.lock);
        CMD_ADDR:    state_next.prdata = '0;
        TABLE_ADDR:  state_next.prdata = 32'(cur_len);
        STATUS_ADDR:
        begin
          state_next.prdata[STAT_STEP_LSB +: STEP_W] = state_reg.step;
          state_next.prdata[STAT_STATE_LSB +: $bits(seq_state_t)] = state_reg.state;
          state_next.prdata[STAT_PENDING]            = state_reg.pend_v;
          state_next.prdata[STAT_SYNC]               = state_reg.sync;
        end
        default:     state_next.pslverr = PWRITE ? 1'b0 : 1'b1;
      endcase
      if (PWRITE)
      begin
        case (PADDR)
          CTRL_ADDR, CMD_ADDR: state_next.pslverr = 1'b0;
          SELECT_ADDR: state_next.pslverr = !seq_ok(PWDATA);
          ONCE_ADDR:   state_next.pslverr = (PWDATA < 32'h1) || (PWDATA > 32'(MAX_ONCE));
          LOCK_ADDR:   state_next.pslverr = (PWDATA < 32'h1) || (PWDATA > 32'(MAX_STEP));
          TABLE_ADDR:  state_next.pslverr = !seq_ok(32'(len_wseq))
                                            || (32'(len_wdata) > 32'(MAX_STEP));
          STATUS_ADDR: state_next.pslverr = 1'b1;
          default:     state_next.pslverr = 1'b1;
        endcase
      end
    end

    if (wr && !state_reg.pslverr)
    begin
      case (PADDR)
        CTRL_ADDR: state_next.ctrl = PWDATA[CTRL_WIDTH-1:0];
        SELECT_ADDR:
        begin
          sel_req = !state_reg.ctrl[CTRL_EXT_SRC];
          sel_seq = PWDATA[SEQ_W-1:0];
        end
        ONCE_ADDR: state_next.once_cnt = PWDATA[ONCE_W-1:0]; // [RQ10]
        LOCK_ADDR: state_next.lock = PWDATA[STEP_W-1:0]; // [RQ11]
        CMD_ADDR:
        begin
          cmd_reset = PWDATA[CMD_SEQ_RESET];
          cmd_trig  = PWDATA[CMD_TRIGGER];
        end
        TABLE_ADDR: len_we = 1'b1;
        default: len_we = 1'b0;
      endcase
    end

    // the external port maps codes 0..255 onto sequences 1..256
    if (state_reg.ctrl[CTRL_EXT_SRC] && EXT_VALID) // [RQ14]
    begin
      sel_req = 1'b1;
      sel_seq = SEQ_W'(EXT_SEL) + SEQ_RESET;
    end
    if (sel_req) // [RQ16]
    begin
      state_next.pend_v   = 1'b1;
      state_next.pend_seq = sel_seq;
    end

    // output stage of the two-entry buffer
    pop = state_reg.out_v && ITEM_READY;
    if (pop)
    begin
      state_next.out_v  = state_reg.skid_v;
      state_next.out_d  = state_reg.skid_d;
      state_next.skid_v = 1'b0;
    end
    in_ready = !state_reg.skid_v;

    // sequencer; timing choice is the same for either selection source [RQ3]
    if (cmd_reset && state_reg.state != ST_IDLE)
    begin
      state_next.state  = ST_PLAY; // [RQ13]
      state_next.step   = '0;
      state_next.passes = '0;
      flush             = 1'b1;
    end
    else if (state_reg.pend_v && (!state_reg.ctrl[CTRL_COHERENT]
             || state_reg.state == ST_IDLE || state_reg.state == ST_DONE))
    begin
      do_start  = 1'b1; // [RQ2]
      start_seq = state_reg.pend_seq;
      flush     = 1'b1;
    end
    else
    begin
      case (state_reg.state)
        ST_BLANK:
        begin
          if (!state_reg.blank_sent && in_ready)
          begin
            push                  = 1'b1; // [RQ5]
            push_d.dc             = 1'b1;
            push_d.seq            = state_reg.active;
            push_d.step           = '0; // [RQ7]
            state_next.blank_sent = 1'b1;
          end
          else if (state_reg.blank_sent && cmd_trig)
          begin
            state_next.state = ST_PLAY; // [RQ5]
            state_next.step  = '0;
          end
        end
        ST_PLAY:
        begin
          if (in_ready)
          begin
            if (state_reg.step >= cur_len)
            begin
              if (state_reg.pend_v)
              begin
                do_start  = 1'b1; // [RQ1]
                start_seq = state_reg.pend_seq;
              end
              else if (state_reg.ctrl[CTRL_ONCE]
                       && state_reg.passes + ONCE_RESET >= state_reg.once_cnt)
                state_next.state = ST_DONE; // [RQ9]
              else
              begin
                push              = 1'b1; // [RQ6]
                push_d.step       = FIRST_STEP;
                state_next.step   = FIRST_STEP;
                state_next.passes = state_reg.passes + ONCE_RESET; // [RQ9]
              end
            end
            else
            begin
              push            = 1'b1;
              push_d.step     = state_reg.step + FIRST_STEP;
              state_next.step = state_reg.step + FIRST_STEP;
            end
            push_d.seq = state_reg.active;
          end
        end
        ST_IDLE, ST_DONE: state_next.step = state_reg.step;
        default: state_next.state = ST_IDLE;
      endcase
    end

    // a new sequence starts: blank item first, or straight to step 1
    if (do_start)
    begin
      state_next.pend_v     = sel_req;
      state_next.active     = start_seq;
      state_next.step       = '0; // [RQ8]
      state_next.passes     = '0;
      state_next.blank_sent = 1'b0;
      state_next.state      = blank_ok ? ST_BLANK : ST_PLAY; // [RQ4]
    end

    if (flush)
    begin
      state_next.out_v  = 1'b0;
      state_next.skid_v = 1'b0;
    end
    else if (push)
    begin
      if (!state_next.out_v)
      begin
        state_next.out_v = 1'b1;
        state_next.out_d = push_d;
      end
      else
      begin
        state_next.skid_v = 1'b1;
        state_next.skid_d = push_d;
      end
    end

    // sync spans the locked step from its take-up to the end of its waveform
    if (STEP_DONE)
      state_next.sync = 1'b0; // [RQ12]
    if (pop && !state_reg.out_d.dc && state_reg.out_d.step == state_reg.lock)
      state_next.sync = 1'b1; // [RQ11] [RQ12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state_reg          <= '0;
      state_reg.ctrl     <= CTRL_RESET;
      state_reg.once_cnt <= ONCE_RESET; // [RQ10]
      state_reg.lock     <= LOCK_RESET; // [RQ11]
      state_reg.active   <= SEQ_RESET;
      state_reg.state    <= ST_IDLE;
    end
    else
      state_reg <= state_next;
  end

  assign PRDATA     = state_reg.prdata;
  assign PREADY     = state_reg.pready;
  assign PSLVERR    = state_reg.pslverr;
  assign ITEM_VALID = state_reg.out_v;
  assign ITEM_DC    = state_reg.out_d.dc;
  assign ITEM_SEQ   = state_reg.out_d.seq;
  assign ITEM_STEP  = state_reg.out_d.step;
  assign SYNC_OUT   = state_reg.sync;

endmodule : seq_switch_ctrl

// ===== verilog/seq_switch_pkg.sv
// constants and types for the waveform sequence switch control block
package seq_switch_pkg;

  // register byte addresses
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] SELECT_ADDR = 8'h04;
  localparam logic [7:0] ONCE_ADDR   = 8'h08;
  localparam logic [7:0] LOCK_ADDR   = 8'h0C;
  localparam logic [7:0] CMD_ADDR    = 8'h10;
  localparam logic [7:0] TABLE_ADDR  = 8'h14;
  localparam logic [7:0] STATUS_ADDR = 8'h18;

  // control register fields
  localparam int CTRL_COHERENT = 0;
  localparam int CTRL_EXT_SRC  = 1;
  localparam int CTRL_BLANK_DC = 2;
  localparam int CTRL_ONCE     = 3;
  localparam int CTRL_ARMED    = 4;
  localparam int CTRL_ARM_BUS  = 5;
  localparam int CTRL_WIDTH    = 6;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 6'h00;

  // command register fields
  localparam int CMD_SEQ_RESET = 0;
  localparam int CMD_TRIGGER   = 1;

  // table length register fields
  localparam int TABLE_LEN_LSB = 0;
  localparam int TABLE_SEQ_LSB = 16;

  // status register fields
  localparam int STAT_STEP_LSB  = 0;
  localparam int STAT_STATE_LSB = 16;
  localparam int STAT_PENDING   = 18;
  localparam int STAT_SYNC      = 19;

  // widths and documented limits
  localparam int SEQ_W   = 10;
  localparam int STEP_W  = 16;
  localparam int ONCE_W  = 25;
  localparam int EXT_W   = 8;
  localparam logic [SEQ_W-1:0]  SEQ_RESET  = 10'h001;
  localparam logic [ONCE_W-1:0] ONCE_RESET = 25'h0000001;
  localparam logic [STEP_W-1:0] LOCK_RESET = 16'h0001;
  localparam logic [STEP_W-1:0] FIRST_STEP = 16'h0001;

  // sequencer states, gray coded along idle -> blank -> play -> done
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BLANK = 2'b01,
    ST_PLAY  = 2'b11,
    ST_DONE  = 2'b10
  } seq_state_t;

endpackage : seq_switch_pkg

// ===== test/seq_switch_ctrl_assertions.sv
// port checks for the sequence switch control
module seq_switch_ctrl_checker
  import seq_switch_pkg::*;
(
  // clock and reset
  input wire logic              REF_CLK,
  input wire logic              RST,
  // apb
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [7:0]        PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  // select port, item stream, sync
  input wire logic [EXT_W-1:0]  EXT_SEL,
  input wire logic              EXT_VALID,
  input wire logic              ITEM_VALID,
  input wire logic              ITEM_READY,
  input wire logic              ITEM_DC,
  input wire logic [SEQ_W-1:0]  ITEM_SEQ,
  input wire logic [STEP_W-1:0] ITEM_STEP,
  input wire logic              STEP_DONE,
  input wire logic              SYNC_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  logic [5:0]        ctrl_q;
  logic [STEP_W-1:0] lock_q;
  logic [SEQ_W-1:0]  sel_q;
  logic              wr_ok;
  logic              take_lock;
  logic              take_ext;
  // shadow of the writes that steer the checks below
  // refused writes leave the registers as they were
  assign wr_ok = PSEL && PENABLE && PWRITE && PREADY && !PSLVERR;
  assign take_lock = ITEM_VALID && ITEM_READY && !ITEM_DC && ITEM_STEP == lock_q;
  assign take_ext = EXT_VALID && ctrl_q[CTRL_EXT_SRC];
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ctrl_q <= CTRL_RESET;
      lock_q <= LOCK_RESET;
      sel_q <= SEQ_RESET;
    end
    else
    begin
      if (wr_ok && PADDR == CTRL_ADDR)
        ctrl_q <= PWDATA[5:0];
      if (wr_ok && PADDR == LOCK_ADDR)
        lock_q <= PWDATA[STEP_W-1:0];
      if (take_ext)
        sel_q <= SEQ_W'(EXT_SEL) + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_apb_answer; PSEL && !PENABLE |=> PREADY; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
  property p_apb_single; PREADY |=> !PREADY; endproperty
  a_apb_single: assert property (p_apb_single) else $error("ready held");
  property p_item_hold;
    ITEM_VALID && !ITEM_READY && !PSEL && !$past(PSEL) && !EXT_VALID && !$past(EXT_VALID)
      |=> ITEM_VALID && $stable(ITEM_STEP) && $stable(ITEM_SEQ);
  endproperty
  a_item_hold: assert property (p_item_hold) else $error("item dropped in stall");
  property p_dc_step; ITEM_VALID && ITEM_DC |-> ITEM_STEP == 16'h0000; endproperty
  a_dc_step: assert property (p_dc_step) else $error("blank item numbered");
  property p_sync_set; take_lock |=> SYNC_OUT; endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync not set");
  property p_sync_clear; SYNC_OUT && STEP_DONE && !take_lock |=> !SYNC_OUT; endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync too long");
  property p_sync_rise; $rose(SYNC_OUT) |-> $past(take_lock); endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("sync without cause");
  property p_imm_ext;
    take_ext && !ctrl_q[CTRL_COHERENT] |-> ##[2:4] (ITEM_VALID && ITEM_SEQ == sel_q);
  endproperty
  a_imm_ext: assert property (p_imm_ext) else $error("port switch late");
  c_sync: cover property (take_lock);
  c_dc: cover property (ITEM_VALID && ITEM_READY && ITEM_DC);
  c_ext: cover property (take_ext);
endmodule : seq_switch_ctrl_checker

bind seq_switch_ctrl seq_switch_ctrl_checker chk (
  .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .EXT_SEL(EXT_SEL), .EXT_VALID(EXT_VALID),
  .ITEM_VALID(ITEM_VALID), .ITEM_READY(ITEM_READY), .ITEM_DC(ITEM_DC), .ITEM_SEQ(ITEM_SEQ),
  .ITEM_STEP(ITEM_STEP), .STEP_DONE(STEP_DONE), .SYNC_OUT(SYNC_OUT));

// ===== test/wave_player_model.sv
// waveform player: takes one item, plays it a few cycles, reports its end
module wave_player_model
#(
  parameter int PLAY_CYCLES = 3
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // item stream and stall request
  input  wire logic item_valid,
  output logic      item_ready,
  input  wire logic hold,
  // end of waveform
  output logic      step_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_reg;
  // busy while playing, so the block's buffer really fills
  assign item_ready = (left_reg == 8'h00) && !hold;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      left_reg <= 8'h00;
      step_done <= 1'b0;
    end
    else
    begin
      step_done <= (left_reg == 8'h01);
      if (item_valid && item_ready)
        left_reg <= 8'(PLAY_CYCLES);
      else if (left_reg != 8'h00)
        left_reg <= left_reg - 8'h01;
    end
  end
endmodule : wave_player_model

// ===== test/test_seq_switch_ctrl.sv
// bench: apb and select tasks, player model, switch scenarios
module test_seq_switch_ctrl
  import seq_switch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ext_valid = 1'b0, hold = 1'b0, pready, pslverr, item_valid, item_ready;
  logic item_dc, step_done, sync_out, got_dc;
  logic [7:0] paddr = 8'h00, ext_sel = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [SEQ_W-1:0] item_seq, got_s;
  logic [STEP_W-1:0] item_step, got_t;
  int fails = 0, n_checks = 0, n, m;
  always #5 ref_clk = ~ref_clk;
  seq_switch_ctrl dut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_SEL(ext_sel), .EXT_VALID(ext_valid), .ITEM_VALID(item_valid),
    .ITEM_READY(item_ready), .ITEM_DC(item_dc), .ITEM_SEQ(item_seq), .ITEM_STEP(item_step),
    .STEP_DONE(step_done), .SYNC_OUT(sync_out));
  wave_player_model player (.clk(ref_clk), .rst(rst), .item_valid(item_valid),
    .item_ready(item_ready), .hold(hold), .step_done(step_done));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // one transfer; for a read d is the expected data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e = 1'b0);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    check(pready === 1'b1 && pslverr === e && (w || prdata === d), "apb transfer");
    if (pready !== 1'b1)
      close_out();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic get();
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (!(item_valid === 1'b1 && item_ready === 1'b1) && k < 400);
    got_s = item_seq;
    got_t = item_step;
    got_dc = item_dc;
    check(item_valid === 1'b1 && item_ready === 1'b1, "no item taken");
    if (!(item_valid === 1'b1 && item_ready === 1'b1))
      close_out();
  endtask : get
  task automatic item(input logic [SEQ_W-1:0] s, input logic [STEP_W-1:0] t, input logic dc);
    get();
    check(got_s === s && got_t === t && got_dc === dc, "item content");
  endtask : item
  task automatic sel(input logic x, input logic [SEQ_W-1:0] s);
    if (x)
    begin
      ext_sel <= 8'(s - 10'h001);
      ext_valid <= 1'b1;
      @(posedge ref_clk);
      ext_valid <= 1'b0;
      @(posedge ref_clk);
    end
    else
      apb(1'b1, SELECT_ADDR, {22'h0, s});
  endtask : sel
  // coherent runs also send a decoy first, which the target must replace
  task automatic switch_to(input logic x, input logic c, input logic [SEQ_W-1:0] os,
                           input logic [STEP_W-1:0] ol, input logic [SEQ_W-1:0] ns);
    int k;
    hold <= 1'b1;
    apb(1'b1, CTRL_ADDR, {30'h0, x, c});
    if (c)
      sel(x, 10'h001);
    sel(x, ns);
    hold <= 1'b0;
    got_t = '0;
    for (k = 0; c && k < 12 && got_t !== ol; k++)
    begin
      get();
      check(got_s === os, "old sequence cut short");
    end
    if (c)
      check(got_t === ol, "old sequence end not reached");
    item(ns, 16'h0001, 1'b0);
  endtask : switch_to
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, CTRL_ADDR, 32'h0);
    apb(1'b0, SELECT_ADDR, 32'h1);
    apb(1'b0, ONCE_ADDR, 32'h1);
    apb(1'b0, LOCK_ADDR, 32'h1);
    apb(1'b0, 8'h1C, 32'h0, 1'b1);
    apb(1'b1, STATUS_ADDR, 32'h0, 1'b1);
    apb(1'b1, ONCE_ADDR, 32'h0, 1'b1);
    apb(1'b1, ONCE_ADDR, 32'h0100_0001, 1'b1);
    apb(1'b1, ONCE_ADDR, 32'h0100_0000);
    apb(1'b0, ONCE_ADDR, 32'h0100_0000);
    apb(1'b1, LOCK_ADDR, 32'h0, 1'b1);
    apb(1'b1, LOCK_ADDR, 32'hC001, 1'b1);
    apb(1'b1, LOCK_ADDR, 32'hC000);
    apb(1'b0, LOCK_ADDR, 32'hC000);
    apb(1'b1, LOCK_ADDR, 32'h1);
    apb(1'b1, SELECT_ADDR, 32'h3E9, 1'b1);
    apb(1'b1, TABLE_ADDR, 32'h03E9_0003, 1'b1);
    apb(1'b1, TABLE_ADDR, 32'h03E8_0003);
    apb(1'b1, TABLE_ADDR, 32'h0001_0003);
    apb(1'b1, TABLE_ADDR, 32'h0002_0004);
    apb(1'b1, TABLE_ADDR, 32'h0003_0003);
    sel(1'b0, 10'h001);
    item(10'h001, 16'h0001, 1'b0);
    switch_to(1'b0, 1'b0, 10'h001, 16'h0003, 10'h002);
    switch_to(1'b0, 1'b1, 10'h002, 16'h0004, 10'h003);
    switch_to(1'b1, 1'b0, 10'h003, 16'h0003, 10'h002);
    switch_to(1'b1, 1'b1, 10'h002, 16'h0004, 10'h003);
    apb(1'b1, LOCK_ADDR, 32'h2);
    for (n = 0; n < 6 && got_t !== 16'h0002; n++)
      get();
    @(posedge ref_clk);
    check(sync_out === 1'b1, "sync missing");
    for (n = 0; n < 20 && step_done !== 1'b1; n++)
      @(posedge ref_clk);
    check(sync_out === 1'b1, "sync short");
    @(posedge ref_clk);
    check(sync_out === 1'b0, "sync long");
    switch_to(1'b0, 1'b0, 10'h003, 16'h0003, 10'h002);
    hold <= 1'b1;
    apb(1'b1, CMD_ADDR, 32'h1);
    hold <= 1'b0;
    got_t = '0;
    for (n = 0; n < 3 && got_t !== 16'h0001; n++)
    begin
      get();
      check(got_t !== 16'h0004, "ran past reset");
    end
    check(got_t === 16'h0001, "no return to first step");
    for (n = 0; n < 2; n++)
    begin
      hold <= 1'b1;
      apb(1'b1, CTRL_ADDR, (n == 0) ? 32'h34 : 32'h04);
      sel(1'b0, 10'h001);
      hold <= 1'b0;
      if (n == 0)
      begin
        get();
        check(got_dc === 1'b1 && got_t === 16'h0000, "blank item");
        repeat (10) @(posedge ref_clk);
        check(item_valid === 1'b0, "ran without trigger");
        apb(1'b0, TABLE_ADDR, 32'h3);
        apb(1'b1, CMD_ADDR, 32'h2);
      end
      for (m = 0; m < 4; m++)
        item(10'h001, 16'(m % 3 + 1), 1'b0);
    end
    hold <= 1'b1;
    apb(1'b1, ONCE_ADDR, 32'h2);
    apb(1'b1, CTRL_ADDR, 32'h08);
    sel(1'b0, 10'h003);
    hold <= 1'b0;
    for (m = 0; m < 6; m++)
      item(10'h003, 16'(m % 3 + 1), 1'b0);
    repeat (20) @(posedge ref_clk);
    check(item_valid === 1'b0, "once mode kept running");
    apb(1'b0, STATUS_ADDR, 32'h0002_0003);
    close_out();
  end
endmodule : test_seq_switch_ctrl
